// file: design/halfrate_timing_params.svh
/*
  Holds the timing counts, register offsets, field positions and reset values
  of the DDR4 gear-down, write leveling and termination sequencer.
  Assumes inclusion by bare name from the design files that need it.
*/
`ifndef HALFRATE_TIMING_PARAMS_SVH
`define HALFRATE_TIMING_PARAMS_SVH

// ==========================================================
// Termination high times in link clocks
`define TERM_BL8_PRE1 4'h6
`define TERM_BL8_PRE2 4'h7
`define TERM_BC4_PRE1 4'h4
`define TERM_BC4_PRE2 4'h5

// ==========================================================
// Sequence intervals in link clocks and picoseconds, gear-down minimum rate and unit factors
`define LVL_DRIVE_CK 12'h019
`define LVL_EDGE_CK 12'h028
`define SYNC_EXTRA_CK 12'h004
`define UPD_MIN_CK 12'h018
`define UPD_MIN_PS 32'h00003A98
`define RSTX_MIN_CK 12'h005
`define RSTX_ADD_PS 32'h00002710
`define SEL_MIN_CK 12'h003
`define SEL_MIN_PS 32'h00000EA4
`define GEAR_MIN_RATE 16'h0A6A
`define PCLK_PERIOD_PS 32'h00002710
`define PS_PER_NS 32'h000003E8

// ==========================================================
// Register offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_TIME 8'h08
`define REG_STAT 8'h0C
`define REG_CAL 8'h10

// ==========================================================
// Field positions and reset values
`define CTRL_PRE2 0
`define CTRL_BC4 1
`define CTRL_PAR 2
`define CTRL_DLLOFF 3
`define CTRL_RATE_LSB 16
`define CMD_GEAR 0
`define CMD_LVL 1
`define CMD_WR 2
`define CMD_CLR 3
`define TIME_RFC_LSB 0
`define TIME_PARLAT_LSB 16
`define STAT_BUSY 0
`define STAT_GEAR 1
`define STAT_REFUSED 2
`define STAT_LVL_FB 3
`define STAT_STATE_LSB 4
`define CAL_SEL_LSB 0
`define CAL_UPD_LSB 16
`define CTRL_RESET 32'h00000000
`define TIME_RESET 32'h0000015E

`endif

// file: design/halfrate_timing_pkg.sv
/*
  Holds the command codes and sequencer states of the timing sequencer.
  Assumes nothing of its surroundings.
*/
package halfrate_timing_pkg;

  // ==========================================================
  // Command placed on the link for one link clock
  typedef enum logic [2:0] {
    CMD_DES = 3'b000,
    CMD_MRS_GEAR = 3'b001,
    CMD_MRS_LEVEL = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_SYNC = 3'b100
  } link_cmd_e;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_G_RST = 4'b0001,
    ST_G_SYNC = 4'b0010,
    ST_G_CMD = 4'b0011,
    ST_L_DRV = 4'b0100,
    ST_L_EDGE = 4'b0101,
    ST_L_FB = 4'b0110,
    ST_W_TERM = 4'b0111
  } seq_state_e;

endpackage

// file: design/link_clock_divider.sv
/*
  Makes the link clock from pclk and a one-cycle tick at each rising edge.
  Assumes one clock pclk and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module link_clock_divider #(
  parameter int HALF = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic ck_out,
  output logic tick
);

  logic [15:0] cnt_reg;

  // ==========================================================
  // Half-period counter, toggles the clock and marks the rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      ck_out <= 1'b0;
      tick <= 1'b0;
    end else if (cnt_reg == 16'(HALF - 1)) begin
      cnt_reg <= 16'h0000;
      ck_out <= ~ck_out;
      tick <= ~ck_out;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

// file: design/interval_timer.sv
/*
  Down counter of link clock ticks that flags expiry of a loaded interval.
  Assumes load is only raised together with tick.
*/
`timescale 1ns/10ps
module interval_timer #(
  parameter int W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);

  logic [W-1:0] count_reg;

  // ==========================================================
  // Load or count down once per tick, stop at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_val;
    end else if (tick && count_reg != '0) begin
      count_reg <= count_reg - W'(1);
    end
  end

  assign done = (count_reg == '0);

endmodule

// file: design/halfrate_sequencer.sv
/*
  Controller that drives a registered DDR4 module through gear-down entry,
  write leveling and writes with termination, keeping the minimum intervals.
  Assumes an APB master on pclk and a device that samples the link clock.
*/
`timescale 1ns/10ps
`include "halfrate_timing_params.svh"
module halfrate_sequencer #(
  parameter int CK_HALF = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ck_out,
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic odt,
  output logic dqs_out,
  output logic dqs_oe,
  input wire logic level_fb
);

  localparam logic [31:0] TCK_PS = 32'(2 * CK_HALF) * `PCLK_PERIOD_PS;

  // Round a picosecond time up to whole link clocks
  function automatic logic [11:0] ceil_ck(input logic [31:0] ps);
    ceil_ck = 12'((ps + TCK_PS - 32'h00000001) / TCK_PS);
  endfunction

  localparam logic [11:0] UPD_PS_CK = ceil_ck(`UPD_MIN_PS);
  localparam logic [11:0] MODE_UPDATE_DELAY = (UPD_PS_CK > `UPD_MIN_CK) ? UPD_PS_CK : `UPD_MIN_CK;
  localparam logic [11:0] SEL_PS_CK = ceil_ck(`SEL_MIN_PS);
  localparam logic [11:0] SELECT_TO_CMD_LATENCY = (SEL_PS_CK > `SEL_MIN_CK) ? SEL_PS_CK : `SEL_MIN_CK;

  logic tick;
  logic done;
  logic fb_meta_reg;
  logic fb_sync_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] time_reg;
  logic [2:0] req_reg;
  logic refused_reg;
  logic gear_on_reg;
  logic lvl_fb_reg;
  logic [3:0] term_reg;
  logic [12:0] seq_ticks_reg;
  halfrate_timing_pkg::seq_state_e state_reg;
  halfrate_timing_pkg::seq_state_e state_next;
  halfrate_timing_pkg::link_cmd_e cmd_reg;
  logic tmr_load;
  logic [11:0] tmr_val;
  logic [11:0] txs_ck;
  logic [11:0] reset_exit_interval;
  logic [3:0] term_sel;
  logic in_idle;
  logic gear_ok;
  logic take_gear;
  logic take_lvl;
  logic take_wr;
  logic apb_wr;
  logic [31:0] rd_mux;
  logic rd_err;

  // ==========================================================
  // Link clock and interval counter
  link_clock_divider #(.HALF(CK_HALF)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ck_out(ck_out),
    .tick(tick)
  );

  interval_timer #(.W(12)) u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(done)
  );

  // Two-flop synchroniser for the leveling feedback pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_meta_reg <= 1'b0;
      fb_sync_reg <= 1'b0;
    end else begin
      fb_meta_reg <= level_fb;
      fb_sync_reg <= fb_meta_reg;
    end
  end

  // ==========================================================
  // Derived intervals from the programmed refresh time and the burst and preamble modes
  always_comb begin
    txs_ck = ceil_ck(32'(time_reg[`TIME_RFC_LSB +: 11]) * `PS_PER_NS + `RSTX_ADD_PS);
    if (ctrl_reg[`CTRL_PAR] && ctrl_reg[`CTRL_DLLOFF]) begin
      txs_ck = txs_ck + 12'(time_reg[`TIME_PARLAT_LSB +: 4]);
    end
    reset_exit_interval = (txs_ck > `RSTX_MIN_CK) ? txs_ck : `RSTX_MIN_CK;
    if (ctrl_reg[`CTRL_BC4]) begin
      term_sel = ctrl_reg[`CTRL_PRE2] ? `TERM_BC4_PRE2 : `TERM_BC4_PRE1;
    end else begin
      term_sel = ctrl_reg[`CTRL_PRE2] ? `TERM_BL8_PRE2 : `TERM_BL8_PRE1;
    end
  end

  // Request arbitration, gear-down first, then leveling, then write
  assign in_idle = (state_reg == halfrate_timing_pkg::ST_IDLE);
  assign gear_ok = (ctrl_reg[`CTRL_RATE_LSB +: 16] >= `GEAR_MIN_RATE);
  assign take_gear = tick && in_idle && req_reg[`CMD_GEAR];
  assign take_lvl = tick && in_idle && !req_reg[`CMD_GEAR] && req_reg[`CMD_LVL];
  assign take_wr = tick && in_idle && !req_reg[`CMD_GEAR] && !req_reg[`CMD_LVL] && req_reg[`CMD_WR];

  // ==========================================================
  // Next state and interval loads, stepping only on ticks; timed states wait for expiry
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_val = 12'h000;
    if (tick) begin
      case (state_reg)
        halfrate_timing_pkg::ST_IDLE: begin
          if (take_gear && gear_ok) begin
            state_next = halfrate_timing_pkg::ST_G_RST;
            tmr_load = 1'b1;
            tmr_val = reset_exit_interval - 12'h001;
          end else if (take_lvl) begin
            state_next = halfrate_timing_pkg::ST_L_DRV;
            tmr_load = 1'b1;
            tmr_val = `LVL_DRIVE_CK - 12'h001;
          end else if (take_wr) begin
            state_next = halfrate_timing_pkg::ST_W_TERM;
            tmr_load = 1'b1;
            tmr_val = 12'(term_sel) - 12'h001;
          end
        end
        halfrate_timing_pkg::ST_G_RST: begin
          if (done) begin
            state_next = halfrate_timing_pkg::ST_G_SYNC;
            tmr_load = 1'b1;
            tmr_val = MODE_UPDATE_DELAY + `SYNC_EXTRA_CK - 12'h001;
          end
        end
        halfrate_timing_pkg::ST_G_SYNC: begin
          if (done) begin
            state_next = halfrate_timing_pkg::ST_G_CMD;
            tmr_load = 1'b1;
            tmr_val = MODE_UPDATE_DELAY - 12'h001;
          end
        end
        halfrate_timing_pkg::ST_L_DRV: begin
          if (done) begin
            state_next = halfrate_timing_pkg::ST_L_EDGE;
            tmr_load = 1'b1;
            tmr_val = `LVL_EDGE_CK - `LVL_DRIVE_CK - 12'h001;
          end
        end
        halfrate_timing_pkg::ST_G_CMD,
        halfrate_timing_pkg::ST_L_EDGE,
        halfrate_timing_pkg::ST_W_TERM: begin
          if (done) begin
            state_next = (state_reg == halfrate_timing_pkg::ST_L_EDGE) ?
                         halfrate_timing_pkg::ST_L_FB : halfrate_timing_pkg::ST_IDLE;
          end
        end
        halfrate_timing_pkg::ST_L_FB: begin
          state_next = halfrate_timing_pkg::ST_IDLE;
        end
        default: begin
          state_next = halfrate_timing_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= halfrate_timing_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Link pins, updated once per link clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= halfrate_timing_pkg::CMD_DES;
      cke <= 1'b0;
      odt <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
      gear_on_reg <= 1'b0;
      lvl_fb_reg <= 1'b0;
      term_reg <= 4'h0;
    end else if (tick) begin
      cmd_reg <= halfrate_timing_pkg::CMD_DES;
      case (state_reg)
        halfrate_timing_pkg::ST_IDLE: begin
          if (take_gear && gear_ok) begin
            cke <= 1'b1;
            gear_on_reg <= 1'b0;
          end else if (take_lvl) begin
            cmd_reg <= halfrate_timing_pkg::CMD_MRS_LEVEL;
          end else if (take_wr) begin
            cmd_reg <= halfrate_timing_pkg::CMD_WRITE;
            odt <= 1'b1;
            term_reg <= term_sel;
          end
        end
        halfrate_timing_pkg::ST_G_RST: begin
          if (done) begin
            cmd_reg <= halfrate_timing_pkg::CMD_MRS_GEAR;
          end
        end
        halfrate_timing_pkg::ST_G_SYNC: begin
          if (done) begin
            cmd_reg <= halfrate_timing_pkg::CMD_SYNC;
          end
        end
        halfrate_timing_pkg::ST_G_CMD: begin
          if (done) begin
            gear_on_reg <= 1'b1;
          end
        end
        halfrate_timing_pkg::ST_L_DRV: begin
          if (done) begin
            dqs_oe <= 1'b1;
          end
        end
        halfrate_timing_pkg::ST_L_EDGE: begin
          if (done) begin
            dqs_out <= 1'b1;
          end
        end
        halfrate_timing_pkg::ST_L_FB: begin
          dqs_out <= 1'b0;
          dqs_oe <= 1'b0;
          lvl_fb_reg <= fb_sync_reg;
        end
        halfrate_timing_pkg::ST_W_TERM: begin
          if (done) begin
            odt <= 1'b0;
          end
        end
        default: begin
          odt <= 1'b0;
        end
      endcase
    end
  end

  assign cmd = cmd_reg;
  assign cs_n = (cmd_reg == halfrate_timing_pkg::CMD_DES);

  // ==========================================================
  // APB slave: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;

  // Read mux
  always_comb begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `REG_CTRL: rd_mux = ctrl_reg;
      `REG_CMD: rd_mux = {29'h0000000, req_reg};
      `REG_TIME: rd_mux = time_reg;
      `REG_STAT: begin
        rd_mux[`STAT_BUSY] = !in_idle;
        rd_mux[`STAT_GEAR] = gear_on_reg;
        rd_mux[`STAT_REFUSED] = refused_reg;
        rd_mux[`STAT_LVL_FB] = lvl_fb_reg;
        rd_mux[`STAT_STATE_LSB +: 4] = state_reg;
      end
      `REG_CAL: begin
        rd_mux[`CAL_SEL_LSB +: 12] = SELECT_TO_CMD_LATENCY;
        rd_mux[`CAL_UPD_LSB +: 12] = MODE_UPDATE_DELAY;
      end
      default: rd_err = 1'b1;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= rd_err;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      time_reg <= `TIME_RESET;
    end else if (apb_wr && paddr == `REG_CTRL) begin
      ctrl_reg <= pwdata;
    end else if (apb_wr && paddr == `REG_TIME) begin
      time_reg <= pwdata;
    end
  end

  // Pending requests, a new write wins over acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= 3'h0;
    end else begin
      req_reg <= (req_reg & ~{take_wr, take_lvl, take_gear}) |
                 ((apb_wr && paddr == `REG_CMD) ? pwdata[2:0] : 3'h0);
    end
  end

  // Sticky refusal of gear-down at slow rates, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_reg <= 1'b0;
    end else if (take_gear && !gear_ok) begin
      refused_reg <= 1'b1;
    end else if (apb_wr && paddr == `REG_CMD && pwdata[`CMD_CLR]) begin
      refused_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Checks: link clocks since the sequence start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_ticks_reg <= 13'h000;
    end else if (tick) begin
      seq_ticks_reg <= in_idle ? 13'h000 : seq_ticks_reg + 13'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_term_high_len: assert property ($fell(odt) |-> seq_ticks_reg == 13'(term_reg))
    else $error("termination high time wrong");
  a_term_choice: assert property ($rose(odt) |-> term_reg == term_sel)
    else $error("termination time not from preamble mode");
  a_level_drive: assert property ($rose(dqs_oe) |-> seq_ticks_reg == 13'(`LVL_DRIVE_CK))
    else $error("strobe drive delay wrong");
  a_level_edge: assert property ($rose(dqs_out) |-> dqs_oe && seq_ticks_reg == 13'(`LVL_EDGE_CK))
    else $error("first strobe edge delay wrong");
  a_gear_rate: assert property (cmd_reg == halfrate_timing_pkg::CMD_MRS_GEAR |-> gear_ok)
    else $error("gear-down issued at slow rate");
  a_gear_mrs_gap: assert property ($rose(cmd_reg == halfrate_timing_pkg::CMD_MRS_GEAR)
      |-> cke && seq_ticks_reg == 13'(reset_exit_interval))
    else $error("gear command too early after cke");
  a_sync_gap: assert property ($rose(cmd_reg == halfrate_timing_pkg::CMD_SYNC)
      |-> seq_ticks_reg == 13'(reset_exit_interval) + 13'(MODE_UPDATE_DELAY) + 13'(`SYNC_EXTRA_CK))
    else $error("sync pulse spacing wrong");
  a_first_cmd: assert property ($rose(gear_on_reg)
      |-> seq_ticks_reg == 13'(reset_exit_interval) + 13'(2 * MODE_UPDATE_DELAY) + 13'(`SYNC_EXTRA_CK))
    else $error("first command spacing wrong");
  a_update_floor: assert property (MODE_UPDATE_DELAY >= `UPD_MIN_CK
      && 32'(MODE_UPDATE_DELAY) * TCK_PS >= `UPD_MIN_PS)
    else $error("update delay too short");
  a_select_floor: assert property (SELECT_TO_CMD_LATENCY >= `SEL_MIN_CK
      && 32'(SELECT_TO_CMD_LATENCY) * TCK_PS >= `SEL_MIN_PS)
    else $error("select latency too short");

  c_gear_done: cover property ($rose(gear_on_reg));
  c_level_done: cover property (state_reg == halfrate_timing_pkg::ST_L_FB && tick);
  c_write_long: cover property ($fell(odt) && term_reg == `TERM_BL8_PRE2);
  c_refused: cover property ($rose(refused_reg));

endmodule

// file: tb/dram_device_model.sv
/*
  Behavioural model of the registered memory module on the far side of the
  sequencer: decodes link commands and answers write leveling.
  Assumes all link signals are registered on pclk by the sequencer.
*/
`timescale 1ns/10ps
module dram_device_model #(
  parameter int WLAT = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck_out,
  input wire logic cs_n,
  input wire logic [2:0] cmd,
  input wire logic dqs_oe,
  input wire logic lvl_val,
  output logic level_fb,
  output logic gear_on
);
  // ==========================================================
  // Command decode at each link clock rising edge
  localparam int RD_LZ_EARLY = 1;
  logic ck_q;
  logic idle_pat;
  int wr_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q <= 1'b0;
      idle_pat <= 1'b0;
      gear_on <= 1'b0;
      wr_cnt <= 0;
    end else begin
      ck_q <= ck_out;
      idle_pat <= ~idle_pat;
      if (ck_out && !ck_q && !cs_n) begin
        if (cmd == 3'h1) gear_on <= 1'b1;
        if (cmd == 3'h3) wr_cnt <= WLAT + 4;
      end else if (ck_out && !ck_q && wr_cnt > 0) begin
        wr_cnt <= wr_cnt - 1;
      end
    end
  end

  // ==========================================================
  // Feedback while strobed, a changing pattern once released
  assign level_fb = dqs_oe ? lvl_val : idle_pat;
endmodule

// file: tb/ddr4_odt_leveling_geardown_timing_test.sv
/*
  Self-checking bench of the gear-down, leveling and termination sequencer.
  Assumes the design files and the device model are compiled first.
*/
`timescale 1ns/10ps
`include "halfrate_timing_params.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module ddr4_odt_leveling_geardown_timing_test;
  localparam int CKH = 1;
  localparam int TCK_PS = 2 * CKH * 10000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, ck_out, cke, cs_n, odt, dqs_out, dqs_oe, level_fb, gear_on;
  logic [2:0] cmd;
  logic lvl_val = 1'b0;
  logic [31:0] rd;
  logic err;
  logic ck_q = 1'b0, cke_q = 1'b0, odt_q = 1'b0, oe_q = 1'b0, dqs_q = 1'b0;
  logic [2:0] cmd_q = 3'h0;
  int err_total = 0;
  int checks = 0;
  int tcnt = 0;
  int t_cke, t_odt_r, t_odt_f, t_oe, t_dqs;
  int t_cmd[5];

  // ==========================================================
  // Clock and instances
  always #5 pclk = ~pclk;
  halfrate_sequencer #(.CK_HALF(CKH)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ck_out(ck_out), .cke(cke), .cs_n(cs_n), .cmd(cmd),
    .odt(odt), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .level_fb(level_fb));
  dram_device_model dev (.pclk(pclk), .presetn(presetn), .ck_out(ck_out), .cs_n(cs_n),
    .cmd(cmd), .dqs_oe(dqs_oe), .lvl_val(lvl_val), .level_fb(level_fb), .gear_on(gear_on));

  // ==========================================================
  // Link monitor: stamps events in link clock ticks
  always @(posedge pclk) begin
    if (ck_out && !ck_q) tcnt++;
    if (cke && !cke_q) t_cke = tcnt;
    if (cmd !== 3'h0 && cmd !== cmd_q && cmd < 3'h5) t_cmd[cmd] = tcnt;
    if (odt && !odt_q) t_odt_r = tcnt;
    if (!odt && odt_q) t_odt_f = tcnt;
    if (dqs_oe && !oe_q) t_oe = tcnt;
    if (dqs_out && !dqs_q) t_dqs = tcnt;
    if (cmd !== 3'h0) `CHK(cs_n, 1'b0)
    ck_q = ck_out;
    cke_q = cke;
    cmd_q = cmd;
    odt_q = odt;
    oe_q = dqs_oe;
    dqs_q = dqs_out;
  end

  // ==========================================================
  // Helpers
  function automatic int cdiv(int a, int b);
    return (a + b - 1) / b;
  endfunction
  function automatic int imax(int a, int b);
    return (a > b) ? a : b;
  endfunction

  // APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 400; i++) begin
      apb(1'b0, `REG_CMD, 32'h0);
      if (rd[2:0] === 3'h0) begin
        apb(1'b0, `REG_STAT, 32'h0);
        if (rd[0] === 1'b0) break;
      end
    end
    if (i == 400) `CHK(rd, 32'h0)
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic give_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, `REG_TIME, 32'h0);
    `CHK(rd, 32'h0000015E)
    apb(1'b0, `REG_CAL, 32'h0);
    `CHK(rd[11:0], 12'(imax(3, cdiv(3748, TCK_PS))))
    `CHK(rd[27:16], 12'(imax(24, cdiv(15000, TCK_PS))))
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test regs done");
  endtask

  task automatic t_refused;
    apb(1'b1, `REG_CTRL, 32'h0A690000);
    apb(1'b1, `REG_CMD, 32'h1);
    wait_idle();
    `CHK({cke, rd[2:1]}, 3'b010)
    apb(1'b1, `REG_CMD, 32'h8);
    apb(1'b0, `REG_STAT, 32'h0);
    `CHK(rd[2], 1'b0)
    $display("test refused done");
  endtask

  task automatic t_writes;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `REG_CTRL, {16'h0A6A, 14'h0, k[1:0]});
      apb(1'b1, `REG_CMD, 32'h4);
      wait_idle();
      `CHK(t_odt_f - t_odt_r, (k[1] ? 4 : 6) + k[0])
      `CHK(t_odt_r, t_cmd[3])
    end
    $display("test writes done");
  endtask

  task automatic t_level(input logic v);
    lvl_val <= v;
    apb(1'b1, `REG_CMD, 32'h2);
    wait_idle();
    `CHK(t_oe - t_cmd[2], 25)
    `CHK(t_dqs - t_cmd[2], 40)
    `CHK({dqs_oe, rd[3]}, {1'b0, v})
    $display("test level done");
  endtask

  // Gear-down with a write queued behind it
  task automatic t_gear(input logic [31:0] ctrl, input int rfc, input int par_lat);
    int rst_exit;
    int mode_update_delay;
    // With parity on and DLL off, parity latency lengthens the refresh time inside the reset-exit maximum
    rst_exit = imax(5, cdiv(rfc * 1000 + 10000, TCK_PS) + ((ctrl[2] & ctrl[3]) ? par_lat : 0));
    mode_update_delay = imax(24, cdiv(15000, TCK_PS));
    apb(1'b1, `REG_TIME, {12'h0, par_lat[3:0], 5'h0, rfc[10:0]});
    apb(1'b1, `REG_CTRL, ctrl);
    apb(1'b1, `REG_CMD, 32'h5);
    wait_idle();
    `CHK(t_cmd[1] - t_cke, rst_exit)
    `CHK(t_cmd[4] - t_cmd[1], mode_update_delay + 4)
    `CHK(t_cmd[3] - t_cmd[4] >= mode_update_delay, 1'b1)
    `CHK({cke, gear_on, rd[1]}, 3'b111)
    $display("test gear done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    do_reset();
    t_regs();
    t_refused();
    t_writes();
    t_level(1'b1);
    t_level(1'b0);
    t_gear(32'h0A6A0004, 351, 6);
    do_reset();
    t_gear(32'h0A6A000C, 350, 6);
    give_verdict();
  end
  initial begin
    #500000;
    err_total++;
    give_verdict();
  end
endmodule
